//--- hdl/rtla_consts.svh
// register offsets, reset values and field positions of the remote
// limit and alarm block; assumes an 8-bit register port from the bus side.
// Notes on behaviour
// - remote low limit: signed reading format, low bits 4:0 zero, resets 0.
// - critical limit is an 8-bit integer in degrees, resets to 85.
// - critical limit writable once, only after unlock bit 1 set.
// - critical stays active until remote below limit minus hysteresis (10).
// - filter field bits 2:1: 00 off, 01/10 minimal, 11 maximum.
// - comparator bit 0 set: alarm pin follows live alarm conditions.
// - status bits 6, 3 and 1 latch until read; clear on read only if condition gone.
// - status bit 7 shows conversion busy, never drives the alarm.
// - status bit 6 set when local above local high setpoint.
// - status bit 3 set when remote below remote low setpoint.
// - status bit 1 set when remote above critical limit.
// - mask bit 6 set stops local high alarm reaching the pin.
`ifndef RTLA_CONSTS_SVH
`define RTLA_CONSTS_SVH
`define RTLA_OFS_STATUS   8'h02
`define RTLA_OFS_LOW_HI   8'h08
`define RTLA_OFS_LOW_LO   8'h14
`define RTLA_OFS_CRIT     8'h19
`define RTLA_OFS_HYST     8'h21
`define RTLA_OFS_CFG      8'hBF
`define RTLA_RST_LOW_HI   8'h00
`define RTLA_RST_LOW_LO   3'h0
`define RTLA_RST_CRIT     8'h55
`define RTLA_RST_HYST     8'h0A
`define RTLA_RST_CFG      3'h0
`define RTLA_CFG_UNLOCK   1
`define RTLA_ST_BUSY      7
`define RTLA_ST_LOCAL_HI  6
`define RTLA_ST_REM_LOW   3
`define RTLA_ST_CRIT      1
`define RTLA_MASK_LOCAL   6
`endif

//--- hdl/rtla_pkg.sv
// types for the remote limit and alarm block; no constants here.
package rtla_pkg;
  typedef logic signed [10:0] rtla_temp_t;
  typedef enum logic [1:0] {
    RTLA_FILT_OFF,
    RTLA_FILT_MIN,
    RTLA_FILT_MAX
  } rtla_filt_e;
endpackage

//--- hdl/rtla_alarm.sv
// remote low/critical limits, filter and comparator config, alarm status.
// assumes reg_wr/reg_rd single-cycle strobes from the serial bus engine and
// readings in signed 11-bit (1/8 degree) form with conv_done pulses.
`timescale 1ns/10ps
`include "rtla_consts.svh"
module rtla_alarm
  import rtla_pkg::*;
(
  input  wire logic        clk_sys,        // 50 MHz system clock
  input  wire logic        srst,           // synchronous reset, high
  input  wire logic        reg_wr,         // register write strobe
  input  wire logic        reg_rd,         // register read strobe
  input  wire logic [7:0]  reg_addr,       // register offset
  input  wire logic [7:0]  reg_wdata,      // write data
  input  wire logic        cfg_unlock_in,  // config bit 1, held elsewhere
  input  wire logic        conv_busy,      // converter busy level
  input  wire logic        conv_done,      // reading ready pulse
  input  wire logic [10:0] remote_temp,    // signed remote reading
  input  wire logic [7:0]  local_temp,     // signed local, whole degrees
  input  wire logic [7:0]  local_high,     // signed local high setpoint
  input  wire logic [7:0]  alarm_mask,     // mask register from outside
  output logic      [7:0]  reg_rdata,      // read data, registered
  output logic      [1:0]  filter_sel,     // filter level 0..2
  output logic             cmp_mode,       // comparator mode bit
  output logic             alert_n_out,    // shared pin, low = alarm
  output logic             alert_n_oe      // pin output enable
);
  // every property below runs on clk_sys and sleeps while srst is high
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  logic [7:0] low_hi_reg, low_hi_next;
  logic [2:0] low_lo_reg, low_lo_next;
  logic [7:0] crit_reg, crit_next, hyst_reg, hyst_next;
  logic [2:0] cfg_reg, cfg_next;
  logic       crit_used_reg, crit_used_next;
  logic [7:0] stat_reg, stat_next, rdata_next;
  logic       crit_act_reg, crit_act_next;
  logic       loc_c_reg, low_c_reg;
  logic       alert_reg, alert_next;
  logic       busy_s1_reg, busy_s2_reg;
  wire  wr_low_hi = reg_wr && reg_addr == `RTLA_OFS_LOW_HI;
  wire  wr_low_lo = reg_wr && reg_addr == `RTLA_OFS_LOW_LO;
  wire  wr_crit   = reg_wr && reg_addr == `RTLA_OFS_CRIT;
  wire  wr_hyst   = reg_wr && reg_addr == `RTLA_OFS_HYST;
  wire  wr_cfg    = reg_wr && reg_addr == `RTLA_OFS_CFG;
  wire  rd_stat   = reg_rd && reg_addr == `RTLA_OFS_STATUS;
  wire  rtla_temp_t low_lim = {low_hi_reg, low_lo_reg};
  wire  signed [10:0] rem = remote_temp;
  wire  signed [8:0]  crit_s = {1'b0, crit_reg};
  wire  signed [9:0]  rel_s = $signed({2'b00, crit_reg}) -
                              $signed({2'b00, hyst_reg});
  wire  signed [11:0] crit_x8 = {crit_s, 3'b000};
  wire  signed [12:0] rel_x8 = {rel_s, 3'b000};
  wire  rem_above = rem > crit_x8;
  wire  rem_below_rel = rem < rel_x8;
  wire  crit_cond = rem_above || (crit_act_reg && !rem_below_rel);
  wire  low_cond = rem < low_lim;
  wire  loc_cond = $signed(local_temp) > $signed(local_high);
  // live conditions are only refreshed on conv_done, so reads see the last
  // completed conversion rather than a half-updated comparison
  wire  loc_now = conv_done ? loc_cond : loc_c_reg;
  wire  low_now = conv_done ? low_cond : low_c_reg;
  wire  crit_now = conv_done ? crit_cond : crit_act_reg;
  wire  crit_ok = wr_crit && cfg_unlock_in && !crit_used_reg;
  wire  loc_en = !alarm_mask[`RTLA_MASK_LOCAL];
  wire  [7:0] alarm_bits = stat_next & 8'h4A;
  wire  [7:0] live_bits = {1'b0, loc_now & loc_en, 2'b00, low_now,
                           1'b0, crit_now, 1'b0};
  wire  any_live = |live_bits;
  wire  any_latched = |(alarm_bits & {1'b1, loc_en, 6'h3F});
  // 01 and 10 both select minimal filtering
  wire  [1:0] filt_next = (cfg_next[2:1] == 2'b11) ? 2'(RTLA_FILT_MAX) :
                          (cfg_next[2:1] == 2'b00) ? 2'(RTLA_FILT_OFF) :
                          2'(RTLA_FILT_MIN);
  always_comb begin
    low_hi_next = wr_low_hi ? reg_wdata : low_hi_reg;
    low_lo_next = wr_low_lo ? reg_wdata[7:5] : low_lo_reg;
    crit_next = crit_ok ? reg_wdata : crit_reg;
    crit_used_next = crit_used_reg | crit_ok;
    hyst_next = wr_hyst ? reg_wdata : hyst_reg;
    // bits 7:3 are dropped; host is expected to write them as zero
    cfg_next = wr_cfg ? reg_wdata[2:0] : cfg_reg;
    crit_act_next = crit_now;
    stat_next = stat_reg;
    if (rd_stat) begin
      // clear only bits whose condition has gone; set wins
      stat_next = {1'b0, loc_now, 2'b00, low_now, 1'b0, crit_now, 1'b0};
    end
    if (conv_done) begin
      stat_next[`RTLA_ST_LOCAL_HI] = stat_next[6] | loc_cond;
      stat_next[`RTLA_ST_REM_LOW] = stat_next[3] | low_cond;
      stat_next[`RTLA_ST_CRIT] = stat_next[1] | crit_cond;
    end
    stat_next[`RTLA_ST_BUSY] = busy_s2_reg;
    alert_next = cfg_reg[0] ? any_live : any_latched;
    rdata_next = 8'h00;
    case (reg_addr)
      `RTLA_OFS_STATUS: rdata_next = stat_reg;
      `RTLA_OFS_LOW_HI: rdata_next = low_hi_reg;
      `RTLA_OFS_LOW_LO: rdata_next = {low_lo_reg, 5'h00};
      `RTLA_OFS_CRIT:   rdata_next = crit_reg;
      `RTLA_OFS_HYST:   rdata_next = hyst_reg;
      `RTLA_OFS_CFG:    rdata_next = {5'h00, cfg_reg};
      default:          rdata_next = 8'h00;
    endcase
  end
  // the one-shot critical write is re-armed only by srst, which stands for
  // power-up here; a warm reset from elsewhere would re-open it
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      low_hi_reg    <= `RTLA_RST_LOW_HI;
      low_lo_reg    <= `RTLA_RST_LOW_LO;
      crit_reg      <= `RTLA_RST_CRIT;
      hyst_reg      <= `RTLA_RST_HYST;
      cfg_reg       <= `RTLA_RST_CFG;
      crit_used_reg <= 1'b0;
    end else begin
      low_hi_reg    <= low_hi_next;
      low_lo_reg    <= low_lo_next;
      crit_reg      <= crit_next;
      hyst_reg      <= hyst_next;
      cfg_reg       <= cfg_next;
      crit_used_reg <= crit_used_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stat_reg     <= 8'h00;
      crit_act_reg <= 1'b0;
      loc_c_reg    <= 1'b0;
      low_c_reg    <= 1'b0;
    end else begin
      stat_reg     <= stat_next;
      crit_act_reg <= crit_act_next;
      loc_c_reg    <= loc_now;
      low_c_reg    <= low_now;
    end
  end

  // conv_busy follows the converter's own timing, so it passes two flops;
  // the busy bit lags the converter by three cycles as a result
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      busy_s1_reg <= 1'b0;
      busy_s2_reg <= 1'b0;
      alert_reg   <= 1'b0;
    end else begin
      busy_s1_reg <= conv_busy;
      busy_s2_reg <= busy_s1_reg;
      alert_reg   <= alert_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata  <= 8'h00;
      filter_sel <= 2'h0;
      cmp_mode   <= 1'b0;
    end else begin
      if (reg_rd) begin
        reg_rdata <= rdata_next;
      end
      filter_sel <= filt_next;
      cmp_mode   <= cfg_next[0];
    end
  end

  assign alert_n_out = 1'b0;
  assign alert_n_oe = alert_reg;
  crit_lock_a: assert property
    (crit_used_reg |=> $stable(crit_reg))
    else $error("critical limit changed after lock");
  crit_wr_a: assert property
    ((wr_crit && !cfg_unlock_in) |=> $stable(crit_reg))
    else $error("critical limit written while locked");
  low_lsb_a: assert property
    ((reg_rd && reg_addr == `RTLA_OFS_LOW_LO) |=> reg_rdata[4:0] == 5'h00)
    else $error("low limit low bits not zero");
  filt_max_a: assert property
    (cfg_reg[2:1] == 2'b11 |-> filter_sel == 2'(RTLA_FILT_MAX))
    else $error("filter level not maximum");
  filt_min_a: assert property
    (cfg_reg[2] != cfg_reg[1] |-> filter_sel == 2'(RTLA_FILT_MIN))
    else $error("filter level not minimal");
  busy_bit_a: assert property
    (stat_reg[`RTLA_ST_BUSY] == $past(busy_s2_reg))
    else $error("busy bit not tracking converter");
  busy_pin_a: assert property
    ((!cfg_reg[0] && stat_next[6:0] == 7'h00) |=> !alert_n_oe)
    else $error("busy bit reached the alarm pin");
  stat_hold_a: assert property
    ((!rd_stat && !conv_done) |=> stat_reg[6:0] == $past(stat_reg[6:0]))
    else $error("status changed without read or conversion");
  stat_clear_a: assert property
    ((rd_stat && !conv_done && !loc_c_reg && !low_c_reg && !crit_act_reg)
     |=> stat_reg[6:0] == 7'h00)
    else $error("status bit kept after its condition went away");
  low_set_a: assert property
    ((conv_done && low_cond) |=> stat_reg[`RTLA_ST_REM_LOW])
    else $error("remote low alarm not set");
  crit_set_a: assert property
    ((conv_done && rem_above) |=> stat_reg[`RTLA_ST_CRIT])
    else $error("critical alarm not set");
  crit_keep_a: assert property
    ((conv_done && crit_act_reg && !rem_below_rel) |=> crit_act_reg)
    else $error("critical condition dropped inside hysteresis");
  crit_rel_a: assert property
    ((conv_done && rem_below_rel) |=> !crit_act_reg)
    else $error("critical condition held below release point");
  loc_set_a: assert property
    ((conv_done && loc_cond) |=> stat_reg[`RTLA_ST_LOCAL_HI])
    else $error("local high alarm not set");
  cmp_pin_a: assert property
    ((cfg_reg[0] && !any_live) |=> !alert_n_oe)
    else $error("comparator pin held without condition");
  cmp_set_a: assert property
    ((cfg_reg[0] && any_live) |=> alert_n_oe)
    else $error("comparator pin not driven with live condition");
  latch_pin_a: assert property
    ((!cfg_reg[0] && any_latched) |=> alert_n_oe)
    else $error("latched alarm not driving the pin");
  local_mask_a: assert property
    ((alarm_mask[`RTLA_MASK_LOCAL] && !cfg_reg[0] &&
      !stat_next[`RTLA_ST_REM_LOW] && !stat_next[`RTLA_ST_CRIT])
     |=> !alert_n_oe)
    else $error("masked local alarm drove the pin");
endmodule

//--- tb/rtla_conv_model.sv
// converter stand-in: busy while go is high, new readings when it drops
// assumes the bench holds go for several cycles per conversion
`timescale 1ns/10ps
module rtla_conv_model (
  input  wire logic        clk_sys,       // system clock
  input  wire logic        go,            // conversion request
  input  wire logic [10:0] rem_in,        // next remote reading
  input  wire logic [7:0]  loc_in,        // next local reading
  output logic             busy,          // converting
  output logic             done = 1'b0,   // one-cycle reading pulse
  output logic      [10:0] rem = 11'h000, // remote reading
  output logic      [7:0]  loc = 8'h00    // local reading
);
  logic go_reg = 1'b0;
  assign busy = go;
  // readings move only with the done pulse, as a real converter would
  always_ff @(posedge clk_sys) begin
    go_reg <= go;
    done   <= go_reg & ~go;
    if (go_reg & ~go) begin
      rem <= rem_in;
      loc <= loc_in;
    end
  end
endmodule

//--- tb/test_rtla_alarm.sv
// self-checking bench for the remote limit and alarm block
// assumes the converter stand-in model and a 50 MHz clock
`timescale 1ns/10ps
module test_rtla_alarm;
  logic        clk_sys = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        go = 1'b0, cfg_unlock_in = 1'b0, busy, done, cmp_mode;
  logic        alert_n_oe, alert_n_out;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, loc_in = 8'h00;
  logic [7:0]  local_high = 8'h20, alarm_mask = 8'h00, loc, reg_rdata;
  logic [10:0] rem_in = 11'h000, rem;
  logic [1:0]  filter_sel;
  int          errors = 0, checks = 0;
  always #10 clk_sys = ~clk_sys;
  rtla_conv_model rtla_conv_model_i (.clk_sys(clk_sys), .go(go),
    .rem_in(rem_in), .loc_in(loc_in), .busy(busy), .done(done),
    .rem(rem), .loc(loc));
  rtla_alarm rtla_alarm_i (.clk_sys(clk_sys), .srst(srst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .cfg_unlock_in(cfg_unlock_in), .conv_busy(busy), .conv_done(done),
    .remote_temp(rem), .local_temp(loc), .local_high(local_high),
    .alarm_mask(alarm_mask), .reg_rdata(reg_rdata), .filter_sel(filter_sel),
    .cmp_mode(cmp_mode), .alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe));
  task automatic chk8(input logic [7:0] g, e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, e);
    chk8({7'h00, g}, {7'h00, e});
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    @(negedge clk_sys);
    chk8(reg_rdata, e);
  endtask
  // b: read status mid-conversion, only used while no alarm is live
  task automatic conv(input logic [10:0] r, input logic [7:0] l, input bit b);
    @(posedge clk_sys);
    rem_in <= r;
    loc_in <= l;
    go     <= 1'b1;
    repeat (4) @(posedge clk_sys);
    if (b) begin
      rd(8'h02, 8'h80);
      chk1(alert_n_oe, 1'b0);
      @(posedge clk_sys);
    end
    go <= 1'b0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic t_reset;
    rd(8'h08, 8'h00);
    rd(8'h14, 8'h00);
    rd(8'h19, 8'h55);
    rd(8'h21, 8'h0A);
    rd(8'hBF, 8'h00);
    rd(8'h03, 8'h00);
    chk1(alert_n_out, 1'b0);
    conv(11'h100, 8'h00, 1'b1);
    rd(8'h02, 8'h00);
  endtask
  task automatic t_filter;
    for (int i = 0; i < 4; i++) begin
      wr(8'hBF, 8'(i * 2 + i % 2));
      chk8({6'h00, filter_sel}, 8'(i - i / 2));
      chk1(cmp_mode, 1'(i % 2));
      rd(8'hBF, 8'(i * 2 + i % 2));
    end
  endtask
  task automatic t_low;
    wr(8'h08, 8'h10);
    wr(8'h14, 8'hFF);
    rd(8'h14, 8'hE0);
    conv(11'h086, 8'h00, 1'b0);
    chk1(alert_n_oe, 1'b1);
    chk1(alert_n_out, 1'b0);
    rd(8'h02, 8'h08);
    rd(8'h02, 8'h08);
    conv(11'h087, 8'h00, 1'b0);
    chk1(alert_n_oe, 1'b0);
    rd(8'h02, 8'h08);
    rd(8'h02, 8'h00);
  endtask
  task automatic critical_temperature;
    wr(8'h19, 8'h30);
    rd(8'h19, 8'h55);
    @(posedge clk_sys);
    cfg_unlock_in <= 1'b1;
    wr(8'h19, 8'h30);
    wr(8'h19, 8'h20);
    rd(8'h19, 8'h30);
    conv(11'h181, 8'h00, 1'b0);
    chk1(alert_n_oe, 1'b1);
    rd(8'h02, 8'h02);
    conv(11'h130, 8'h00, 1'b0);
    rd(8'h02, 8'h02);
    conv(11'h12F, 8'h00, 1'b0);
    chk1(alert_n_oe, 1'b0);
    rd(8'h02, 8'h02);
    rd(8'h02, 8'h00);
  endtask
  task automatic t_local;
    @(posedge clk_sys);
    alarm_mask <= 8'h40;
    conv(11'h100, 8'h21, 1'b0);
    chk1(alert_n_oe, 1'b0);
    rd(8'h02, 8'h40);
    @(posedge clk_sys);
    alarm_mask <= 8'h00;
    conv(11'h100, 8'h21, 1'b0);
    chk1(alert_n_oe, 1'b1);
    conv(11'h100, 8'h20, 1'b0);
    chk1(alert_n_oe, 1'b0);
    rd(8'h02, 8'h40);
    rd(8'h02, 8'h00);
    // latched mode: the pin follows the status bit, not the live condition
    wr(8'hBF, 8'h00);
    conv(11'h100, 8'h21, 1'b0);
    chk1(alert_n_oe, 1'b1);
    conv(11'h100, 8'h20, 1'b0);
    chk1(alert_n_oe, 1'b1);
    rd(8'h02, 8'h40);
    chk1(alert_n_oe, 1'b0);
    rd(8'h02, 8'h00);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset;
    t_filter;
    t_low;
    critical_temperature;
    t_local;
    end_sim;
  end
endmodule
